/* hw/tcp_unit.sv */
// Purpose: 16-bit timer/counter/PWM with capture, dead band and kill
// Assumes: Config inputs are static or from clk domain
// Notes: Pin inputs pass three flops; kill also acts combinationally
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tcp_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire tcp_pkg::tcp_cfg_t cfg,
    // Pins
    input wire logic trigger_input_zero,
    input wire logic kill_in,
    // Results
    output logic [`TCP_CNT_W-1:0] count,
    output logic [`TCP_CNT_W-1:0] capture,
    output logic running,
    output tcp_pkg::tcp_out_t outs
);
    typedef struct packed {
        logic [2:0] trig_sync;
        logic [2:0] kill_sync;
        logic trig_level;
        logic kill_level;
        logic [`TCP_DIV_W-1:0] div_cnt;
        logic tick;
        logic [`TCP_CNT_W-1:0] cnt;
        logic [`TCP_CNT_W-1:0] cap;
        logic stopped;
        logic pwm_raw;
        logic [`TCP_DEAD_W-1:0] dead_cnt;
        logic true_q;
        logic comp_q;
        logic match;
        logic wrap;
    } tcp_state_t;

    tcp_state_t state_reg;
    tcp_state_t state_next;
    logic trig_rise;
    logic kill_now;

    // Edge taken only once 2nd and 3rd sync stages agree
    assign trig_rise = (state_reg.trig_sync[1] == state_reg.trig_sync[2]) &&
                       state_reg.trig_sync[2] && !state_reg.trig_level;
    // Direct path so kill bites before the next tick, no firmware involved
    assign kill_now = state_reg.kill_level || (state_reg.kill_sync[1] && state_reg.kill_sync[2]);

    always_comb begin
        state_next = state_reg;
        state_next.trig_sync = {state_reg.trig_sync[1:0], trigger_input_zero};
        state_next.kill_sync = {state_reg.kill_sync[1:0], kill_in};
        if (state_reg.trig_sync[1] == state_reg.trig_sync[2]) begin
            state_next.trig_level = state_reg.trig_sync[2];
        end
        if (state_reg.kill_sync[1] == state_reg.kill_sync[2]) begin
            state_next.kill_level = state_reg.kill_sync[2];
        end
        state_next.tick = 1'b0;
        state_next.match = 1'b0;
        state_next.wrap = 1'b0;
        // Dropping enable clears a one-shot stop but keeps the count
        if (!cfg.enable) begin
            state_next.div_cnt = '0;
            state_next.stopped = 1'b0;
        end else if (state_reg.div_cnt >= cfg.divider) begin
            state_next.div_cnt = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + `TCP_DIV_W'(1);
        end
        if (trig_rise) begin
            state_next.cap = state_reg.cnt;
        end
        if (state_reg.tick && !state_reg.stopped) begin
            if (state_reg.cnt == cfg.period) begin
                state_next.wrap = 1'b1;
                if (cfg.one_shot) begin
                    state_next.stopped = 1'b1;
                end else begin
                    state_next.cnt = `TCP_CNT_RESET;
                end
            end else begin
                state_next.cnt = state_reg.cnt + `TCP_CNT_W'(1);
            end
            state_next.match = (state_reg.cnt == cfg.compare);
        end
        // High while count below compare
        state_next.pwm_raw = (state_reg.cnt < cfg.compare);
        // Dead band: both outputs low until delay expires after each edge
        if (state_reg.pwm_raw != state_next.pwm_raw) begin
            state_next.dead_cnt = cfg.dead_band;
            state_next.true_q = 1'b0;
            state_next.comp_q = 1'b0;
        end else if (state_reg.dead_cnt != '0) begin
            state_next.dead_cnt = state_reg.dead_cnt - `TCP_DEAD_W'(1);
        end else begin
            state_next.true_q = state_reg.pwm_raw;
            state_next.comp_q = !state_reg.pwm_raw;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.cnt <= `TCP_CNT_RESET;
            state_reg.cap <= `TCP_CNT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        outs.match = state_reg.match;
        outs.wrap = state_reg.wrap;
        if (kill_now) begin
            outs.pwm_true_output = cfg.kill_true_level;
            outs.pwm_comp_output = cfg.kill_comp_level;
        end else begin
            outs.pwm_true_output = state_reg.true_q;
            outs.pwm_comp_output = state_reg.comp_q;
        end
    end

    assign count = state_reg.cnt;
    assign capture = state_reg.cap;
    assign running = cfg.enable && !state_reg.stopped;

    property p_kill_out;
        @(posedge clk) disable iff (rst)
        (state_reg.kill_sync[2] && state_reg.kill_sync[1]) |->
            (outs.pwm_true_output == cfg.kill_true_level) && (outs.pwm_comp_output == cfg.kill_comp_level);
    endproperty
    a_kill_out: assert property (p_kill_out) else $error("kill did not force outputs");

    property p_kill_fast;
        @(posedge clk) disable iff (rst)
        $rose(kill_in) && !kill_now ##1 kill_in [*3] |-> kill_now;
    endproperty
    a_kill_fast: assert property (p_kill_fast) else $error("kill late");

    property p_capture;
        @(posedge clk) disable iff (rst)
        trig_rise |=> capture == $past(state_reg.cnt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_reload;
        @(posedge clk) disable iff (rst)
        state_reg.tick && !state_reg.stopped && cfg.enable && !cfg.one_shot && state_reg.cnt == cfg.period
            |=> count == `TCP_CNT_RESET;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at period");

    property p_stop;
        @(posedge clk) disable iff (rst)
        state_reg.tick && !state_reg.stopped && cfg.enable && cfg.one_shot && state_reg.cnt == cfg.period
            |=> state_reg.stopped && $stable(count);
    endproperty
    a_stop: assert property (p_stop) else $error("no stop at period");

    property p_count_step;
        @(posedge clk) disable iff (rst)
        state_reg.tick && !state_reg.stopped && state_reg.cnt != cfg.period
            |=> count == $past(state_reg.cnt) + `TCP_CNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");

    property p_no_tick_hold;
        @(posedge clk) disable iff (rst)
        !state_reg.tick |=> $stable(count);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved off tick");

    property p_duty;
        @(posedge clk) disable iff (rst)
        1'b1 |=> state_reg.pwm_raw == ($past(state_reg.cnt) < $past(cfg.compare));
    endproperty
    a_duty: assert property (p_duty) else $error("duty compare wrong");

    property p_no_overlap;
        @(posedge clk) disable iff (rst)
        !kill_now |-> !(outs.pwm_true_output && outs.pwm_comp_output);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");

    // Both switch drives must drop in the very cycle the raw level flips
    property p_dead_gap;
        @(posedge clk) disable iff (rst)
        $changed(state_reg.pwm_raw) |-> !state_reg.true_q && !state_reg.comp_q;
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead band gap");

    property p_match_pulse;
        @(posedge clk) disable iff (rst)
        state_reg.tick && !state_reg.stopped && state_reg.cnt == cfg.compare |=> outs.match;
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match pulse missing");

    property p_wrap_pulse;
        @(posedge clk) disable iff (rst)
        state_reg.tick && !state_reg.stopped && state_reg.cnt == cfg.period |=> outs.wrap;
    endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse missing");

    // Capture must only move on a filtered pin edge
    property p_capture_hold;
        @(posedge clk) disable iff (rst)
        !trig_rise |=> $stable(capture);
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("capture moved without event");
endmodule // tcp_unit
`default_nettype wire

/* hw/tcp_defines.svh */
// Purpose: Constants for the timer/counter/PWM unit
// Assumes: 100 MHz system clock
// Notes: Counts in cycles of the divided peripheral tick
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH
`define TCP_CNT_W 16
`define TCP_CNT_RESET 16'h0000
`define TCP_PERIOD_RESET 16'hffff
`define TCP_CMP_RESET 16'h8000
`define TCP_DIV_W 16
`define TCP_DEAD_W 8
`endif

/* hw/tcp_pkg.sv */
// Purpose: Types for the timer/counter/PWM unit
// Assumes: tcp_defines.svh included first
// Notes: Config and output groups travel as structs
`include "tcp_defines.svh"
package tcp_pkg;
    typedef enum logic [1:0] {
        TCP_PWM_HIGH,
        TCP_PWM_LOW
    } tcp_level_t;

    typedef struct packed {
        logic enable;
        logic one_shot;
        logic [`TCP_DIV_W-1:0] divider;
        logic [`TCP_CNT_W-1:0] period;
        logic [`TCP_CNT_W-1:0] compare;
        logic [`TCP_DEAD_W-1:0] dead_band;
        logic kill_true_level;
        logic kill_comp_level;
    } tcp_cfg_t;

    typedef struct packed {
        logic pwm_true_output;
        logic pwm_comp_output;
        logic match;
        logic wrap;
    } tcp_out_t;
endpackage : tcp_pkg

/* dv/tcp_pin_model.sv */
// Purpose: Pin side: trigger and kill sources, switch pair watcher
// Assumes: Commands come from the bench in clk domain
// Notes: Latches overlap of the two switch drives once kill has been low for 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
    // Clock
    input wire logic clk,
    input wire logic rst,
    // Commands
    input wire logic fire_trig,
    input wire logic fire_kill,
    // Pins
    input wire tcp_pkg::tcp_out_t outs,
    output logic trigger_input_zero,
    output logic kill_in,
    output logic shoot_through
);
    logic [3:0] calm_cnt;

    assign trigger_input_zero = fire_trig;
    assign kill_in = fire_kill;
    // Cycles since kill went low; a kill may pick both-high levels on purpose
    always_ff @(posedge clk) begin
        if (rst || fire_kill) calm_cnt <= 4'h0;
        else if (calm_cnt != 4'hf) calm_cnt <= calm_cnt + 4'h1;
    end
    // Both switches on would short the supply
    always_ff @(posedge clk) begin
        if (rst) shoot_through <= 1'b0;
        else if (calm_cnt >= 4'h8 && outs.pwm_true_output && outs.pwm_comp_output) shoot_through <= 1'b1;
    end
endmodule // tcp_pin_model
`default_nettype wire

/* dv/tb_timer_counter_pwm_unit.sv */
// Purpose: Self-checking bench for the timer/counter/PWM unit
// Assumes: Period 9 gives a ten-tick PWM frame
// Notes: Duty is counted over two frames in steady state
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tb_timer_counter_pwm_unit;
    logic clk, rst, fire_trig, fire_kill, shoot_through, running, trig_pin, kill_pin;
    tcp_pkg::tcp_cfg_t cfg;
    tcp_pkg::tcp_out_t outs;
    logic [`TCP_CNT_W-1:0] count, capture, top;
    int fail_count, checks_done, nt, nc, nm, nw, i, k;
    // Rows: compare, dead band, true-high and comp-high cycles in 20
    logic [15:0] rows [3][4] = '{'{16'h0004, 16'h0000, 16'h0006, 16'h000a},
        '{16'h0006, 16'h0001, 16'h0008, 16'h0004}, '{16'h0005, 16'h0002, 16'h0004, 16'h0004}};
    tcp_unit i_dut (.clk(clk), .rst(rst), .cfg(cfg), .trigger_input_zero(trig_pin), .kill_in(kill_pin),
        .count(count), .capture(capture), .running(running), .outs(outs));
    tcp_pin_model i_pins (.clk(clk), .rst(rst), .fire_trig(fire_trig), .fire_kill(fire_kill), .outs(outs),
        .trigger_input_zero(trig_pin), .kill_in(kill_pin), .shoot_through(shoot_through));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1; cfg = '0; fire_trig = 1'b0; fire_kill = 1'b0; fail_count = 0; checks_done = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk("count", 16'h0000, count);
        for (i = 0; i < 3; i++) begin
            @(posedge clk);
            cfg <= '{enable: 1'b1, one_shot: 1'b0, divider: 16'h0000, period: 16'h0009, compare: rows[i][0],
                dead_band: rows[i][1][7:0], kill_true_level: 1'b0, kill_comp_level: 1'b0};
            tick(40);
            nt = 0; nc = 0; top = '0;
            nm = 0;
            nw = 0;
            repeat (20) begin
                nt += outs.pwm_true_output; nc += outs.pwm_comp_output;
                nm += outs.match;
                nw += outs.wrap;
                if (count > top) top = count;
                tick(1);
            end
            chk("period_top", 16'h0009, top);
            chk("true_high", rows[i][2], 16'(nt));
            chk("comp_high", rows[i][3], 16'(nc));
            chk("match_pulses", 16'h0002, 16'(nm));
            chk("wrap_pulses", 16'h0002, 16'(nw));
        end
        // Kill forced while the pair is switching, every level combination
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            cfg.kill_true_level <= k[0]; cfg.kill_comp_level <= k[1]; fire_kill <= 1'b1;
            tick(6);
            chk("kill_true", {15'h0, k[0]}, {15'h0, outs.pwm_true_output});
            tick(7);
            chk("kill_comp", {15'h0, k[1]}, {15'h0, outs.pwm_comp_output});
            @(posedge clk);
            fire_kill <= 1'b0;
            tick(10);
        end
        @(posedge clk);
        cfg <= '{enable: 1'b1, one_shot: 1'b0, divider: 16'h0003, period: 16'hffff, compare: 16'h0000,
            dead_band: 8'h00, kill_true_level: 1'b0, kill_comp_level: 1'b0};
        tick(20);
        top = count;
        for (nt = 0; nt < 50 && count == top; nt++) tick(1);
        top = count;
        for (nt = 0; nt < 50 && count == top; nt++) tick(1);
        chk("tick_spacing", 16'h0004, 16'(nt));
        // Mid-run reset clears a count left above the new period
        @(posedge clk);
        rst <= 1'b1;
        cfg.enable <= 1'b0;
        tick(3);
        @(posedge clk);
        rst <= 1'b0;
        cfg.period <= 16'h0005;
        cfg.one_shot <= 1'b1;
        cfg.enable <= 1'b1;
        tick(1);
        chk("reset_count", `TCP_CNT_RESET, count);
        chk("reset_capture", `TCP_CNT_RESET, capture);
        chk("running_start", 16'h0001, {15'h0, running});
        tick(60);
        chk("one_shot_hold", 16'h0005, count);
        chk("running", 16'h0000, {15'h0, running});
        @(posedge clk);
        fire_trig <= 1'b1;
        tick(3);
        @(posedge clk);
        fire_trig <= 1'b0;
        tick(10);
        chk("capture", 16'h0005, capture);
        chk("overlap", 16'h0000, {15'h0, shoot_through});
        tally_and_finish;
    end
endmodule // tb_timer_counter_pwm_unit
`default_nettype wire
